// file: ccg_clock_ctrl.sv
// Clock control: ratio dividers, per-module clock stop gating and the register slave.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module ccg_clock_ctrl
   import ccg_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Domain clock enables.
   output ccg_dom_tick_t dom_tick,
   // Per-module clock enables.
   output ccg_mod_en_t mod_clk_en
);

   // Register state.
   logic [CCG_RATIO_W-1:0] clock_ratio_control_ff;
   logic [CCG_STOP_W-1:0] module_stop_control_two_ff;
   logic [CCG_STOP_W-1:0] module_stop_control_three_ff;

   // Bus handshake state.
   logic wait_ff;
   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;
   logic bus_req;
   logic do_write;
   logic [3:0] word_addr;

   // Divider wiring.
   logic [CCG_FIELD_W-1:0] dom_ratio [CCG_NUM_DOM];
   logic [CCG_NUM_DOM-1:0] dom_tick_vec;
   ccg_dom_tick_t dom_tick_ff;

   // Module gating wiring.
   logic [CCG_NUM_MOD-1:0] stop_vec;
   logic [CCG_NUM_MOD-1:0] src_tick_vec;
   logic [CCG_NUM_MOD-1:0] run_ff;
   logic [CCG_NUM_MOD-1:0] mod_en_ff;

   // Avalon-MM slave.

   assign bus_req = avs_read | avs_write;
   assign word_addr = {avs_address[3:2], 2'h0};

   // Every access takes exactly one wait cycle: waitrequest drops for one cycle
   // after the request is first seen, and that is the edge the master completes on.
   assign do_write = avs_write & ~wait_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_ff <= 1'b1;
      end else if (bus_req && wait_ff) begin
         wait_ff <= 1'b0;
      end else begin
         wait_ff <= 1'b1;
      end
   end

   // Read data are captured while waitrequest is high and stand only during the
   // cycle in which it is low, so a stale word never lingers on the bus.
   always_comb begin
      nxt_readdata = 32'h0000_0000;
      unique case (word_addr)
         CCG_OFS_RATIO: begin
            nxt_readdata[CCG_RATIO_W-1:0] = clock_ratio_control_ff;
         end
         CCG_OFS_STOP2: begin
            nxt_readdata[CCG_STOP_W-1:0] = module_stop_control_two_ff;
         end
         CCG_OFS_STOP3: begin
            nxt_readdata[CCG_STOP_W-1:0] = module_stop_control_three_ff;
         end
         CCG_OFS_STATUS: begin
            nxt_readdata[CCG_NUM_MOD-1:0] = run_ff;
            nxt_readdata[31:28] = 4'h0;
         end
         default: begin
            nxt_readdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata_ff <= 32'h0000_0000;
      end else if (avs_read && wait_ff) begin
         readdata_ff <= nxt_readdata;
      end else begin
         readdata_ff <= 32'h0000_0000;
      end
   end

   assign avs_readdata = readdata_ff;
   assign avs_waitrequest = wait_ff;

   // Registers.

   // The ratio register spans byte lanes 0 and 1; all bits are stored as written.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clock_ratio_control_ff <= CCG_RATIO_RST;
      end else if (do_write && word_addr == CCG_OFS_RATIO) begin
         if (avs_byteenable[0]) begin
            clock_ratio_control_ff[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            clock_ratio_control_ff[15:8] <= avs_writedata[15:8];
         end
      end
   end

   // Reserved bits are kept as written; software is expected to write bit 5
   // as one and bits 2 to 0 as zero, and the gating never looks at them.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         module_stop_control_two_ff <= CCG_STOP2_RST;
      end else if (do_write && word_addr == CCG_OFS_STOP2 && avs_byteenable[0]) begin
         module_stop_control_two_ff <= avs_writedata[CCG_STOP_W-1:0];
      end
   end

   // Bits 1 and 0 are reserved and expected to be written as ones.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         module_stop_control_three_ff <= CCG_STOP3_RST;
      end else if (do_write && word_addr == CCG_OFS_STOP3 && avs_byteenable[0]) begin
         module_stop_control_three_ff <= avs_writedata[CCG_STOP_W-1:0];
      end
   end

   // Ratio dividers.

   // Code n divides the base clock by n + 1, so 000 passes it through and
   // 001 gives half of it.
   assign dom_ratio[CCG_DOM_CORE] =
      clock_ratio_control_ff[CCG_CORE_LSB +: CCG_FIELD_W];
   assign dom_ratio[CCG_DOM_BUS] =
      clock_ratio_control_ff[CCG_BUS_LSB +: CCG_FIELD_W];
   assign dom_ratio[CCG_DOM_PERIPH] =
      clock_ratio_control_ff[CCG_PERIPH_LSB +: CCG_FIELD_W];
   assign dom_ratio[CCG_DOM_TIMER2] =
      clock_ratio_control_ff[CCG_TIMER2_LSB +: CCG_FIELD_W];
   assign dom_ratio[CCG_DOM_TIMER1] =
      clock_ratio_control_ff[CCG_TIMER1_LSB +: CCG_FIELD_W];

   generate
      for (genvar d = 0; d < CCG_NUM_DOM; d++) begin : g_div
         ccg_ratio_div u_div (
            .clk(clk),
            .rst(rst),
            .ratio(dom_ratio[d]),
            .tick_ff(dom_tick_vec[d]),
            .applied_ff()
         );
      end
   endgenerate

   // Domain ticks are retimed once more so that they line up with the module
   // enables, which are derived from the same divider output.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dom_tick_ff <= '0;
      end else begin
         dom_tick_ff.core <= dom_tick_vec[CCG_DOM_CORE];
         dom_tick_ff.bus <= dom_tick_vec[CCG_DOM_BUS];
         dom_tick_ff.periph <= dom_tick_vec[CCG_DOM_PERIPH];
         dom_tick_ff.second_timer <= dom_tick_vec[CCG_DOM_TIMER2];
         dom_tick_ff.first_timer <= dom_tick_vec[CCG_DOM_TIMER1];
      end
   end

   assign dom_tick = dom_tick_ff;

   // Module clock stop gating.

   // Memories run from the core clock, the transfer engines from the bus
   // clock, and the serial units from the peripheral clock.
   assign stop_vec = {
      module_stop_control_two_ff[CCG_RAM_STOP_BIT],
      module_stop_control_two_ff[CCG_ROM_STOP_BIT],
      module_stop_control_two_ff[CCG_XFER_STOP_BIT],
      module_stop_control_two_ff[CCG_DMA_STOP_BIT],
      module_stop_control_three_ff[CCG_TWI_STOP_BIT],
      module_stop_control_three_ff[CCG_FSER_STOP_BIT],
      module_stop_control_three_ff[CCG_SER2_STOP_BIT],
      module_stop_control_three_ff[CCG_SER1_STOP_BIT],
      module_stop_control_three_ff[CCG_SER0_STOP_BIT],
      module_stop_control_three_ff[CCG_SSER_STOP_BIT]
   };

   assign src_tick_vec = {
      dom_tick_vec[CCG_DOM_CORE],
      dom_tick_vec[CCG_DOM_CORE],
      dom_tick_vec[CCG_DOM_BUS],
      dom_tick_vec[CCG_DOM_BUS],
      dom_tick_vec[CCG_DOM_PERIPH],
      dom_tick_vec[CCG_DOM_PERIPH],
      dom_tick_vec[CCG_DOM_PERIPH],
      dom_tick_vec[CCG_DOM_PERIPH],
      dom_tick_vec[CCG_DOM_PERIPH],
      dom_tick_vec[CCG_DOM_PERIPH]
   };

   // A stop or restart only takes hold on a tick of the module's own domain,
   // so a module never sees a clipped clock period. The run bit records the
   // state last applied and is what software sees in the status word.
   generate
      for (genvar m = 0; m < CCG_NUM_MOD; m++) begin : g_gate
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               run_ff[m] <= 1'b1;
               mod_en_ff[m] <= 1'b0;
            end else if (src_tick_vec[m]) begin
               run_ff[m] <= ~stop_vec[m];
               mod_en_ff[m] <= ~stop_vec[m];
            end else begin
               mod_en_ff[m] <= 1'b0;
            end
         end
      end
   endgenerate

   assign mod_clk_en = ccg_mod_en_t'(mod_en_ff);

endmodule : ccg_clock_ctrl
`default_nettype wire

// file: ccg_clock_ctrl_chk.sv
// Checker with bus and clock gating assertions for the clock control block.
`timescale 1ns/10ps
`default_nettype none
module ccg_clock_ctrl_chk
   import ccg_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Clock enables.
   input wire ccg_dom_tick_t dom_tick,
   input wire ccg_mod_en_t mod_clk_en
);
   logic [15:0] ratio_ff;
   logic [3:0] since_ff;
   logic ok;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Ratio changes land at a period end, so divider checks wait until a write has settled.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ratio_ff <= CCG_RATIO_RST;
         since_ff <= 4'h0;
      end else if (avs_write && !avs_waitrequest && avs_address[3:2] == 2'h0) begin
         if (avs_byteenable[0]) ratio_ff[7:0] <= avs_writedata[7:0];
         if (avs_byteenable[1]) ratio_ff[15:8] <= avs_writedata[15:8];
         since_ff <= 4'h0;
      end else if (since_ff != 4'hf) begin
         since_ff <= since_ff + 4'h1;
      end
   end
   assign ok = since_ff >= 4'ha;
   property p_core_x1;
      ok && ratio_ff[14:12] == 3'h0 |-> dom_tick.core;
   endproperty
   a_core_x1: assert property (p_core_x1) else $error("core tick missing");
   property p_bus_half;
      ok && ratio_ff[11:9] == 3'h1 |-> dom_tick.bus != $past(dom_tick.bus);
   endproperty
   a_bus_half: assert property (p_bus_half) else $error("bus tick not halved");
   property p_periph_half;
      ok && ratio_ff[8:6] == 3'h1 |-> dom_tick.periph != $past(dom_tick.periph);
   endproperty
   a_periph_half: assert property (p_periph_half) else $error("periph tick wrong");
   property p_tmr2_half;
      ok && ratio_ff[5:3] == 3'h1 |-> dom_tick.second_timer ^ $past(dom_tick.second_timer);
   endproperty
   a_tmr2_half: assert property (p_tmr2_half) else $error("timer2 tick wrong");
   property p_tmr1_half;
      ok && ratio_ff[2:0] == 3'h1 |=> $changed(dom_tick.first_timer);
   endproperty
   a_tmr1_half: assert property (p_tmr1_half) else $error("timer1 tick wrong");
   property p_mem_gate;
      mod_clk_en.ram || mod_clk_en.rom |-> dom_tick.core;
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("memory enable off tick");
   property p_xfer_gate;
      mod_clk_en.transfer_ctrl || mod_clk_en.dma |-> dom_tick.bus;
   endproperty
   a_xfer_gate: assert property (p_xfer_gate) else $error("transfer enable off tick");
   property p_ser_gate;
      |mod_clk_en[4:0] |-> dom_tick.periph;
   endproperty
   a_ser_gate: assert property (p_ser_gate) else $error("serial tick");
   property p_ack_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("bus answer not one cycle");
   property p_rdata_zero;
      avs_waitrequest |-> avs_readdata == 32'h0;
   endproperty
   a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside answer");
   c_write: cover property (avs_write && !avs_waitrequest);
   c_bus_half: cover property (ok && ratio_ff[11:9] == 3'h1 && dom_tick.bus);
   c_dma_run: cover property (mod_clk_en.dma);
endmodule : ccg_clock_ctrl_chk
bind ccg_clock_ctrl ccg_clock_ctrl_chk i_ccg_clock_ctrl_chk (.clk, .rst, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .dom_tick, .mod_clk_en);
`default_nettype wire

// file: ccg_clock_ctrl_tb.sv
// Self-checking testbench for the clock control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
   n_compared++; \
   if ((a) !== (b)) begin \
      num_errors++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); \
   end \
end
module ccg_clock_ctrl_tb
   import ccg_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   ccg_dom_tick_t dom_tick;
   ccg_mod_en_t mod_clk_en;
   logic [31:0] rd;
   int num_errors = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   ccg_clock_ctrl i_ccg_clock_ctrl (.clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .dom_tick,
      .mod_clk_en);
   task results;
      $display("errors %0d of %0d compares", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   // The request is held until a rising edge samples waitrequest low; read data are
   // taken at that same edge. One edge passes before the next request is raised.
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int k;
      k = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         k++;
         if (k > 20) begin
            num_errors++;
            results();
         end
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   // Two-wire domain is not fixed, so its pulse count is only judged while stopped.
   task check_cfg(input logic [15:0] r, input logic [7:0] s2, input logic [7:0] s3);
      int dc[5];
      int mc[10];
      logic [9:0] st;
      st = {s2[7], s2[6], s2[4], s2[3], s3[7:2]};
      bus(1'b1, CCG_OFS_RATIO, {16'h0, r}, 4'hf);
      bus(1'b1, CCG_OFS_STOP2, {24'h0, s2}, 4'hf);
      bus(1'b1, CCG_OFS_STOP3, {24'h0, s3}, 4'hf);
      bus(1'b0, CCG_OFS_RATIO, 32'h0, 4'hf);
      `CHK(rd, {16'h0, r})
      bus(1'b0, CCG_OFS_STOP2, 32'h0, 4'hf);
      `CHK(rd, {24'h0, s2})
      bus(1'b0, CCG_OFS_STOP3, 32'h0, 4'hf);
      `CHK(rd, {24'h0, s3})
      bus(1'b0, CCG_OFS_STATUS, 32'h0, 4'hf);
      `CHK(rd, {22'h0, ~st})
      repeat (8) @(posedge clk);
      dc = '{default: 0};
      mc = '{default: 0};
      repeat (60) begin
         @(negedge clk);
         for (int i = 0; i < 5; i++) dc[i] += (dom_tick[i] === 1'b1);
         for (int j = 0; j < 10; j++) mc[j] += (mod_clk_en[j] === 1'b1);
      end
      for (int i = 0; i < 5; i++) `CHK(dc[i], 60 / (r[3*i +: 3] + 1))
      for (int j = 6; j < 10; j++) `CHK(mc[j], st[j] ? 0 : dc[j > 7 ? 4 : 3])
      for (int j = 0; j < 6; j++)
         if (j != 5 || st[j]) `CHK(mc[j], st[j] ? 0 : dc[2])
   endtask : check_cfg
   task t_reset;
      bus(1'b0, CCG_OFS_RATIO, 32'h0, 4'hf);
      `CHK(rd, {16'h0, CCG_RATIO_RST})
      bus(1'b0, CCG_OFS_STOP2, 32'h0, 4'hf);
      `CHK(rd, {24'h0, CCG_STOP2_RST})
      bus(1'b0, CCG_OFS_STOP3, 32'h0, 4'hf);
      `CHK(rd, {24'h0, CCG_STOP3_RST})
      bus(1'b0, CCG_OFS_STATUS, 32'h0, 4'hf);
      `CHK(rd, 32'h0000_03ff)
   endtask : t_reset
   task t_halves;
      check_cfg(16'h0249, 8'h28, 8'hbf);
   endtask : t_halves
   task t_thirds;
      check_cfg(16'h0492, 8'hf0, 8'h43);
   endtask : t_thirds
   task t_lanes;
      bus(1'b1, CCG_OFS_RATIO, 32'hffff_ff00, 4'h1);
      bus(1'b1, CCG_OFS_STOP2, 32'hffff_ff55, 4'he);
      bus(1'b0, CCG_OFS_RATIO, 32'h0, 4'hf);
      `CHK(rd, 32'h0000_0400)
      bus(1'b0, CCG_OFS_STOP2, 32'h0, 4'hf);
      `CHK(rd, 32'h0000_00f0)
   endtask : t_lanes
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_halves();
      t_thirds();
      t_lanes();
      results();
   end
endmodule : ccg_clock_ctrl_tb
`default_nettype wire

// file: ccg_pkg.sv
// Package with register map, field layout and reset values of the clock control block.
package ccg_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [3:0] CCG_OFS_RATIO = 4'h0;
   localparam logic [3:0] CCG_OFS_STOP2 = 4'h4;
   localparam logic [3:0] CCG_OFS_STOP3 = 4'h8;
   localparam logic [3:0] CCG_OFS_STATUS = 4'hc;

   // Register widths.
   localparam int CCG_RATIO_W = 16;
   localparam int CCG_STOP_W = 8;
   localparam int CCG_FIELD_W = 3;
   localparam int CCG_NUM_DOM = 5;
   localparam int CCG_NUM_MOD = 10;

   // Ratio field positions inside clock_ratio_control.
   localparam int CCG_CORE_LSB = 12;
   localparam int CCG_BUS_LSB = 9;
   localparam int CCG_PERIPH_LSB = 6;
   localparam int CCG_TIMER2_LSB = 3;
   localparam int CCG_TIMER1_LSB = 0;

   // Stop bit positions inside module_stop_control_two.
   localparam int CCG_RAM_STOP_BIT = 7;
   localparam int CCG_ROM_STOP_BIT = 6;
   localparam int CCG_XFER_STOP_BIT = 4;
   localparam int CCG_DMA_STOP_BIT = 3;

   // Stop bit positions inside module_stop_control_three.
   localparam int CCG_TWI_STOP_BIT = 7;
   localparam int CCG_FSER_STOP_BIT = 6;
   localparam int CCG_SER2_STOP_BIT = 5;
   localparam int CCG_SER1_STOP_BIT = 4;
   localparam int CCG_SER0_STOP_BIT = 3;
   localparam int CCG_SSER_STOP_BIT = 2;

   // Ratio code for a divide by one; code n divides by n + 1.
   localparam logic [2:0] CCG_RATIO_X1 = 3'h0;

   // Reset values.
   localparam logic [15:0] CCG_RATIO_RST = 16'h0000;
   localparam logic [7:0] CCG_STOP2_RST = 8'h20;
   localparam logic [7:0] CCG_STOP3_RST = 8'h03;

   // Domain indices for the divider array.
   localparam int CCG_DOM_CORE = 0;
   localparam int CCG_DOM_BUS = 1;
   localparam int CCG_DOM_PERIPH = 2;
   localparam int CCG_DOM_TIMER2 = 3;
   localparam int CCG_DOM_TIMER1 = 4;

   // Domain clock enables.
   typedef struct packed {
      logic core;
      logic bus;
      logic periph;
      logic second_timer;
      logic first_timer;
   } ccg_dom_tick_t;

   // Per-module clock enables, also the layout of the status run bits.
   typedef struct packed {
      logic ram;
      logic rom;
      logic transfer_ctrl;
      logic dma;
      logic two_wire;
      logic fifo_serial;
      logic serial_ch2;
      logic serial_ch1;
      logic serial_ch0;
      logic sync_serial;
   } ccg_mod_en_t;

endpackage : ccg_pkg

// file: ccg_ratio_div.sv
// Ratio divider that turns the base clock into a periodic one-cycle clock enable.
`timescale 1ns/10ps
`default_nettype none
module ccg_ratio_div
   import ccg_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Ratio code.
   input wire logic [CCG_FIELD_W-1:0] ratio,
   // Clock enable.
   output logic tick_ff,
   output logic [CCG_FIELD_W-1:0] applied_ff
);

   logic [CCG_FIELD_W-1:0] count_ff;

   // A new ratio is only taken at the end of a period, so no period is ever cut short.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_ff <= CCG_RATIO_X1;
         applied_ff <= CCG_RATIO_X1;
         tick_ff <= 1'b0;
      end else if (count_ff == CCG_RATIO_X1) begin
         count_ff <= ratio;
         applied_ff <= ratio;
         tick_ff <= 1'b1;
      end else begin
         count_ff <= count_ff - 3'h1;
         tick_ff <= 1'b0;
      end
   end

endmodule : ccg_ratio_div
`default_nettype wire
